// file: design/rtc_pkg.sv
// Shared constants, register map and types of the clock event block.
`default_nettype none
package rtc_pkg;
   // Clock rate and the millisecond time base.
   localparam int CLK_NS = 50;
   localparam int MS_NS = 1_000_000;
   localparam int CYC_PER_MS = MS_NS / CLK_NS;
   localparam logic [9:0] MS_LAST = 10'h3E7;
   // Sixteenths alternate 62 and 63 ms, giving 62.5 ms on average.
   localparam logic [5:0] SIX_SHORT = 6'h3D;
   localparam logic [5:0] SIX_LONG = 6'h3E;

   // Register map.
   localparam logic [4:0] A_MSLO = 5'h00;
   localparam logic [4:0] A_MSHI = 5'h01;
   localparam logic [4:0] A_SEC = 5'h02;
   localparam logic [4:0] A_MONTH = 5'h06;
   localparam logic [4:0] A_CTRL = 5'h07;
   localparam logic [4:0] A_CAL = 5'h08;
   localparam logic [4:0] A_WDOG = 5'h09;
   localparam logic [4:0] A_TMRVAL = 5'h0A;
   localparam logic [4:0] A_TMRCTL = 5'h0B;
   localparam logic [4:0] A_FLAGS = 5'h0C;
   localparam logic [4:0] A_TMRCNT = 5'h0D;
   localparam logic [1:0] A_ALM_HI = 2'h2;
   localparam logic [2:0] ALM_FIELDS = 3'h5;

   // Control register bits.
   localparam int C_HALT = 0;
   localparam int C_OSTOP = 1;
   localparam int C_OSCILLATOR_FAIL_IRQ_ENABLE = 4;
   localparam int C_A2EN = 6;
   localparam int C_A1EN = 7;
   localparam logic [7:0] CTRL_RST = 8'h01;

   // Flag register bits and timer control bit.
   localparam int F_TF = 0;
   localparam int F_AF2 = 1;
   localparam int F_AF1 = 2;
   localparam int F_WDF = 3;
   localparam int F_OF = 4;
   localparam int T_TE = 2;

   // Time field limits, index 0 seconds up to 4 months.
   localparam logic [7:0] SEC_LAST = 8'h3B;
   localparam logic [7:0] HOUR_LAST = 8'h17;
   localparam logic [7:0] MONTH_LAST = 8'h0C;
   localparam logic [7:0] DAY_FIRST = 8'h01;

   typedef enum logic [2:0] {
      WD_OFF = 3'b001,
      WD_RUN = 3'b010,
      WD_EXPIRED = 3'b100
   } wd_state_t;

   function automatic logic [7:0] monthDays(input logic [7:0] month);
      case (month)
         8'h02: monthDays = 8'h1C;
         8'h04, 8'h06, 8'h09, 8'h0B: monthDays = 8'h1E;
         default: monthDays = 8'h1F;
      endcase
   endfunction

   // Watchdog resolution in sixteenths: 1/16, 1/4, 1 and 4 seconds.
   function automatic logic [10:0] wdScale(input logic [1:0] res);
      case (res)
         2'h0: wdScale = 11'h001;
         2'h1: wdScale = 11'h004;
         2'h2: wdScale = 11'h010;
         default: wdScale = 11'h040;
      endcase
   endfunction
endpackage
`default_nettype wire

// file: design/rtc_tick_if.sv
// Tick and calibration signals between the time base and the clock core.
`timescale 1ns/1ns
`default_nettype none
interface rtc_tick_if;
   logic msTick;
   logic sixTick;
   logic oscStop;
   logic [5:0] cal;
   modport gen(output msTick, output sixTick, input oscStop, input cal);
   modport sink(input msTick, input sixTick, output oscStop, output cal);
endinterface
`default_nettype wire

// file: design/rtc_time_base.sv
// Calibrated millisecond and sixteenth-second tick generator.
`timescale 1ns/1ns
`default_nettype none
module rtc_time_base #(
   parameter int unsigned CYC_PER_MS = rtc_pkg::CYC_PER_MS
) (
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Ticks out, controls in.
   rtc_tick_if.gen tb
);
   typedef struct packed {
      logic [15:0] cyc;
      logic [5:0] msInSix;
      logic phase;
      logic msTick;
      logic sixTick;
   } base_t;

   base_t s;
   base_t n;
   logic [15:0] period;

   // Sign set lengthens the millisecond, so the clock runs slower.
   always_comb begin
      n = s;
      n.msTick = 1'b0;
      n.sixTick = 1'b0;
      if (tb.cal[5]) begin
         period = 16'(CYC_PER_MS) + {11'h000, tb.cal[4:0]};
      end else begin
         period = 16'(CYC_PER_MS) - {11'h000, tb.cal[4:0]};
      end
      if (!tb.oscStop) begin
         if (s.cyc >= period - 16'h0001) begin
            n.cyc = 16'h0000;
            n.msTick = 1'b1;
            if (s.msInSix == (s.phase ? rtc_pkg::SIX_LONG : rtc_pkg::SIX_SHORT)) begin
               n.msInSix = 6'h00;
               n.phase = !s.phase;
               n.sixTick = 1'b1;
            end else begin
               n.msInSix = s.msInSix + 6'h01;
            end
         end else begin
            n.cyc = s.cyc + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
      end else if (ce) begin
         s <= n;
      end
   end

   assign tb.msTick = s.msTick;
   assign tb.sixTick = s.sixTick;
endmodule
`default_nettype wire

// file: design/rtc_event_core.sv
// Clock core: time keeping, alarms, countdown timer, watchdog and registers.
`timescale 1ns/1ns
`default_nettype none
module rtc_event_core #(
   parameter int unsigned CYC_PER_MS = rtc_pkg::CYC_PER_MS
) (
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Register port.
   input wire logic [4:0] addr,
   input wire logic [7:0] wrData,
   input wire logic wrEn,
   input wire logic rdEn,
   output logic [7:0] rdData,
   // Pins.
   input wire logic pwrFail,
   input wire logic oscFail,
   output logic wdogOut,
   output logic ofAlarm
);
   typedef struct packed {
      logic [1:0] pfSync;
      logic [1:0] ofSync;
      logic [9:0] ms;
      logic [4:0][7:0] tm;
      logic [1:0][4:0][7:0] alm;
      logic [1:0] almPrev;
      logic [7:0] ctrl;
      logic [5:0] cal;
      logic [4:0] wdMult;
      logic [1:0] wdRes;
      logic [10:0] wdCnt;
      rtc_pkg::wd_state_t wdState;
      logic [7:0] tmrVal;
      logic [7:0] tmrCnt;
      logic [2:0] tmrCtl;
      logic tf;
      logic af1;
      logic af2;
      logic watchdog_expired_flag;
      logic oscFailFlag;
      logic [7:0] rdData;
      logic wdogOut;
      logic ofAlarm;
   } core_t;

   core_t s;
   core_t n;
   logic secTick;
   logic minTick;
   logic tmrTick;
   logic carry;
   logic tfSet;
   logic a1Set;
   logic a2Set;
   logic wdSet;
   logic flagRead;
   logic [1:0] match;
   logic [7:0] rdValue;

   rtc_tick_if tb();

   rtc_time_base #(.CYC_PER_MS(CYC_PER_MS)) u_base (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .tb(tb)
   );

   assign tb.oscStop = s.ctrl[rtc_pkg::C_OSTOP];
   assign tb.cal = s.cal;

   function automatic logic [7:0] fieldLast(input int i, input logic [7:0] month);
      case (i)
         0, 1: fieldLast = rtc_pkg::SEC_LAST;
         2: fieldLast = rtc_pkg::HOUR_LAST;
         3: fieldLast = rtc_pkg::monthDays(month);
         default: fieldLast = rtc_pkg::MONTH_LAST;
      endcase
   endfunction

   function automatic logic [7:0] fieldFirst(input int i);
      fieldFirst = (i >= 3) ? rtc_pkg::DAY_FIRST : 8'h00;
   endfunction

   function automatic logic [10:0] wdLoad(input logic [4:0] mult, input logic [1:0] res);
      wdLoad = 11'({6'h00, mult} * rtc_pkg::wdScale(res));
   endfunction

   always_comb begin
      n = s;
      n.pfSync = {s.pfSync[0], pwrFail};
      n.ofSync = {s.ofSync[0], oscFail};
      secTick = 1'b0;
      carry = 1'b0;
      tfSet = 1'b0;
      wdSet = 1'b0;
      flagRead = rdEn && (addr == rtc_pkg::A_FLAGS);

      // Time keeping stops entirely while halted.
      if (tb.msTick && !s.ctrl[rtc_pkg::C_HALT]) begin
         if (s.ms == rtc_pkg::MS_LAST) begin
            n.ms = 10'h000;
            secTick = 1'b1;
         end else begin
            n.ms = s.ms + 10'h001;
         end
      end
      minTick = secTick && (s.tm[0] == rtc_pkg::SEC_LAST);
      carry = secTick;
      for (int i = 0; i < 5; i++) begin
         if (carry) begin
            if (s.tm[i] >= fieldLast(i, s.tm[4])) begin
               n.tm[i] = fieldFirst(i);
            end else begin
               n.tm[i] = s.tm[i] + 8'h01;
               carry = 1'b0;
            end
         end
      end

      // Alarms fire once on entering a match; no pin, only flags.
      match[0] = s.ctrl[rtc_pkg::C_A1EN] && (s.tm == s.alm[0]);
      match[1] = s.ctrl[rtc_pkg::C_A2EN] && (s.tm == s.alm[1]);
      n.almPrev = match;
      a1Set = match[0] && !s.almPrev[0];
      a2Set = match[1] && !s.almPrev[1];

      // Countdown timer tick source.
      case (s.tmrCtl[1:0])
         2'h0: tmrTick = tb.msTick;
         2'h1: tmrTick = tb.sixTick;
         2'h2: tmrTick = secTick;
         default: tmrTick = minTick;
      endcase
      if (s.tmrCtl[rtc_pkg::T_TE] && tmrTick) begin
         if (s.tmrCnt <= 8'h01) begin
            n.tmrCnt = s.tmrVal;
            tfSet = 1'b1;
         end else begin
            n.tmrCnt = s.tmrCnt - 8'h01;
         end
      end

      // Watchdog counts sixteenths of a second.
      case (s.wdState)
         rtc_pkg::WD_RUN: begin
            if (tb.sixTick) begin
               if (s.wdCnt <= 11'h001) begin
                  wdSet = 1'b1;
                  n.wdogOut = 1'b1;
                  n.wdState = rtc_pkg::WD_EXPIRED;
               end else begin
                  n.wdCnt = s.wdCnt - 11'h001;
               end
            end
         end
         rtc_pkg::WD_OFF, rtc_pkg::WD_EXPIRED: begin
            n.wdCnt = s.wdCnt;
         end
         default: n.wdState = rtc_pkg::WD_OFF;
      endcase

      // Register writes.
      if (wrEn) begin
         if (addr >= rtc_pkg::A_SEC && addr <= rtc_pkg::A_MONTH) begin
            n.tm[3'(addr - rtc_pkg::A_SEC)] = wrData;
            n.ms = 10'h000;
         end
         if (addr[4:3] >= rtc_pkg::A_ALM_HI && addr[2:0] < rtc_pkg::ALM_FIELDS) begin
            n.alm[addr[3]][addr[2:0]] = wrData;
         end
         case (addr)
            rtc_pkg::A_CTRL: n.ctrl = wrData;
            rtc_pkg::A_CAL: n.cal = wrData[5:0];
            rtc_pkg::A_WDOG: begin
               n.wdMult = wrData[4:0];
               n.wdRes = wrData[6:5];
               n.wdCnt = wdLoad(wrData[4:0], wrData[6:5]);
               n.wdogOut = 1'b0;
               if (wrData[4:0] == 5'h00) begin
                  n.wdState = rtc_pkg::WD_OFF;
               end else begin
                  n.wdState = rtc_pkg::WD_RUN;
               end
            end
            rtc_pkg::A_TMRVAL: begin
               n.tmrVal = wrData;
               n.tmrCnt = wrData;
            end
            rtc_pkg::A_TMRCTL: n.tmrCtl = wrData[2:0];
            rtc_pkg::A_FLAGS: begin
               if (!wrData[rtc_pkg::F_OF]) begin
                  n.oscFailFlag = 1'b0;
               end
            end
            default: n.cal = n.cal;
         endcase
      end

      // Register reads; data stand only in the following cycle.
      case (addr)
         rtc_pkg::A_MSLO: rdValue = s.ms[7:0];
         rtc_pkg::A_MSHI: rdValue = {6'h00, s.ms[9:8]};
         rtc_pkg::A_CTRL: rdValue = s.ctrl;
         rtc_pkg::A_CAL: rdValue = {2'h0, s.cal};
         rtc_pkg::A_WDOG: rdValue = {1'b0, s.wdRes, s.wdMult};
         rtc_pkg::A_TMRVAL: rdValue = s.tmrVal;
         rtc_pkg::A_TMRCTL: rdValue = {5'h00, s.tmrCtl};
         rtc_pkg::A_FLAGS: rdValue = {3'h0, s.oscFailFlag, s.watchdog_expired_flag, s.af1, s.af2, s.tf};
         rtc_pkg::A_TMRCNT: rdValue = s.tmrCnt;
         default: rdValue = 8'h00;
      endcase
      if (addr >= rtc_pkg::A_SEC && addr <= rtc_pkg::A_MONTH) begin
         rdValue = s.tm[3'(addr - rtc_pkg::A_SEC)];
      end
      if (addr[4:3] >= rtc_pkg::A_ALM_HI && addr[2:0] < rtc_pkg::ALM_FIELDS) begin
         rdValue = s.alm[addr[3]][addr[2:0]];
      end
      n.rdData = rdEn ? rdValue : 8'h00;

      // A flag read clears all flags but the oscillator fail flag, but an event in the same cycle wins.
      if (flagRead) begin
         n.tf = 1'b0;
         n.af1 = 1'b0;
         n.af2 = 1'b0;
         n.watchdog_expired_flag = 1'b0;
      end
      if (tfSet) begin
         n.tf = 1'b1;
      end
      if (a1Set) begin
         n.af1 = 1'b1;
      end
      if (a2Set) begin
         n.af2 = 1'b1;
      end
      if (wdSet) begin
         n.watchdog_expired_flag = 1'b1;
      end
      if (s.ofSync[1]) begin
         n.oscFailFlag = 1'b1;
      end
      if (s.pfSync[1]) begin
         n.ctrl[rtc_pkg::C_HALT] = 1'b1;
      end
      n.ofAlarm = n.oscFailFlag && n.ctrl[rtc_pkg::C_OSCILLATOR_FAIL_IRQ_ENABLE];
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
         s.ctrl <= rtc_pkg::CTRL_RST;
         s.tm[3] <= rtc_pkg::DAY_FIRST;
         s.tm[4] <= rtc_pkg::DAY_FIRST;
         s.wdState <= rtc_pkg::WD_OFF;
      end else if (ce) begin
         s <= n;
      end
   end

   assign rdData = s.rdData;
   assign wdogOut = s.wdogOut;
   assign ofAlarm = s.ofAlarm;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   chk_tf_sticky: assert property (s.tf && !(ce && flagRead) |=> s.tf)
      else $error("Timer flag dropped without a flag read.");
   chk_flag_read_clear: assert property (ce && flagRead && !tfSet && !a1Set |=> !s.tf && !s.af1)
      else $error("Flag read did not clear timer or alarm flag.");
   chk_wdf_read_clear: assert property (ce && flagRead && !wdSet |=> !s.watchdog_expired_flag)
      else $error("Flag read did not clear watchdog flag.");
   chk_timer_reload: assert property (ce && !wrEn && s.tmrCtl[rtc_pkg::T_TE] && tmrTick
      && s.tmrCnt == 8'h01 |=> s.tmrCnt == $past(s.tmrVal) && s.tf)
      else $error("Timer did not reload and flag at count one.");
   chk_timer_step: assert property (ce && !wrEn && s.tmrCtl[rtc_pkg::T_TE] && tmrTick
      && s.tmrCnt > 8'h01 |=> s.tmrCnt == $past(s.tmrCnt) - 8'h01)
      else $error("Timer did not count down by one.");
   chk_timer_hold: assert property (!s.tmrCtl[rtc_pkg::T_TE] && !wrEn |=> $stable(s.tmrCnt))
      else $error("Timer moved while disabled.");
   chk_reload_value: assert property (!wrEn |=> $stable(s.tmrVal))
      else $error("Timer start value changed without a write.");
   chk_wdog_restart: assert property (ce && wrEn && addr == rtc_pkg::A_WDOG |=>
      !s.wdogOut && s.wdCnt == wdLoad($past(wrData[4:0]), $past(wrData[6:5])))
      else $error("Watchdog write did not restart the period.");
   chk_wdog_zero: assert property (s.wdState == rtc_pkg::WD_OFF && !s.watchdog_expired_flag && !wrEn
      |=> s.wdState == rtc_pkg::WD_OFF && !s.watchdog_expired_flag && !s.wdogOut)
      else $error("Disabled watchdog raised its flag.");
   chk_wdog_expire: assert property (ce && !wrEn && s.wdState == rtc_pkg::WD_RUN
      && tb.sixTick && s.wdCnt == 11'h001 |=> s.watchdog_expired_flag && s.wdogOut)
      else $error("Watchdog expiry missed.");
   chk_alarm2_gate: assert property (ce && !s.ctrl[rtc_pkg::C_A2EN] && !s.af2 |=> !s.af2)
      else $error("Alarm two fired while disabled.");
   chk_halt_freeze: assert property (s.ctrl[rtc_pkg::C_HALT] && !wrEn |=> $stable(s.tm)
      && $stable(s.ms))
      else $error("Time moved while halted.");
   chk_halt_power: assert property (ce && s.pfSync[1] |=> s.ctrl[rtc_pkg::C_HALT])
      else $error("Power loss did not set halt.");
   chk_ctrl_write: assert property (ce && wrEn && addr == rtc_pkg::A_CTRL && !s.pfSync[1]
      |=> s.ctrl == $past(wrData))
      else $error("Control write not stored.");
   chk_ms_range: assert property (s.ms <= rtc_pkg::MS_LAST)
      else $error("Millisecond count out of range.");
   chk_of_clear: assert property (ce && wrEn && addr == rtc_pkg::A_FLAGS && !s.ofSync[1]
      && !wrData[rtc_pkg::F_OF] |=> !s.oscFailFlag && !s.ofAlarm)
      else $error("Oscillator fail flag not cleared by write.");
   chk_alarm_one_set: assert property (ce && s.ctrl[rtc_pkg::C_A1EN] && !s.almPrev[0]
      && s.tm == s.alm[0] |=> s.af1)
      else $error("Alarm one match did not set its flag.");

   cov_timer_flag: cover property (ce && tfSet);
   cov_alarm_one: cover property (ce && a1Set);
   cov_alarm_two: cover property (ce && a2Set);
   cov_wdog_fire: cover property (ce && wdSet);
   cov_flag_read: cover property (ce && flagRead && s.tf ##1 !s.tf);
endmodule
`default_nettype wire

// file: verification/rtc_host_model.sv
// Host model that drives the clock's register port.
`timescale 1ns/1ns
`default_nettype none
module rtc_host_model (
   // Clock.
   input wire logic clk,
   // Register port.
   output var logic [4:0] addr,
   output var logic [7:0] wrData,
   output var logic wrEn,
   output var logic rdEn,
   input wire logic [7:0] rdData
);
   initial begin
      addr = 5'h00;
      wrData = 8'h00;
      wrEn = 1'b0;
      rdEn = 1'b0;
   end

   // One-cycle write strobe beside address and data.
   task automatic hostWrite(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge clk);
      wrEn <= 1'b0;
   endtask

   // Read data are taken at the edge that closes the cycle after the strobe.
   task automatic hostRead(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      @(posedge clk);
      d = rdData;
   endtask
endmodule
`default_nettype wire

// file: verification/tb_rtc_alarm_timer_watchdog.sv
// Self-checking testbench of the clock event core.
`timescale 1ns/1ns
`default_nettype none
module tb_rtc_alarm_timer_watchdog;
   localparam int CPM = 20;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic pwrFail = 1'b0;
   logic oscFail = 1'b0;
   logic ce = 1'b1;
   logic [4:0] addr;
   logic [7:0] wrData;
   logic wrEn;
   logic rdEn;
   logic [7:0] rdData;
   logic wdogOut;
   logic ofAlarm;
   logic [7:0] d;
   logic [9:0] m1;
   logic [9:0] m2;
   logic [10:0] dt;
   int numErrors = 0;
   int nCompared = 0;
   logic [7:0] wdVal[2] = '{8'h02, 8'h21};
   int wdLow[2] = '{1000, 3000};
   int wdHigh[2] = '{1800, 2200};

   always #25 clk = ~clk;

   rtc_event_core #(.CYC_PER_MS(CPM)) uut (
      .clk(clk), .nrst(nrst), .ce(ce),
      .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
      .pwrFail(pwrFail), .oscFail(oscFail), .wdogOut(wdogOut), .ofAlarm(ofAlarm)
   );

   rtc_host_model host (
      .clk(clk), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData)
   );

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      nCompared++;
      if (seen !== exp) begin
         numErrors++;
         $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic expectReg(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] v;
      host.hostRead(a, v);
      check(v, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic readMs(output logic [9:0] ms);
      logic [7:0] lo;
      logic [7:0] hi;
      host.hostRead(rtc_pkg::A_MSHI, hi);
      host.hostRead(rtc_pkg::A_MSLO, lo);
      ms = {hi[1:0], lo};
   endtask

   task automatic setAlarm(input logic [4:0] base, input logic [7:0] sec);
      host.hostWrite(base, sec);
      host.hostWrite(base + 5'h01, 8'h00);
      host.hostWrite(base + 5'h02, 8'h00);
      host.hostWrite(base + 5'h03, 8'h01);
      host.hostWrite(base + 5'h04, 8'h01);
   endtask

   task automatic endTest(input string name);
      $display("Test %s finished, %0d mismatches so far", name, numErrors);
   endtask

   task automatic complete_run();
      $display("Compared %0d values, %0d mismatches", nCompared, numErrors);
      if (numErrors == 0 && nCompared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // The longest path is about 60000 cycles; this cuts a hang short.
   initial begin
      #(100000 * 50);
      numErrors++;
      complete_run();
   end

   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      expectReg(rtc_pkg::A_CTRL, rtc_pkg::CTRL_RST);
      expectReg(rtc_pkg::A_FLAGS, 8'h00);
      host.hostWrite(5'h0E, 8'hFF);
      expectReg(5'h0E, 8'h00);
      for (int i = 1; i < 5; i++) begin
         host.hostWrite(rtc_pkg::A_CTRL, 8'(8'h01 << i));
         expectReg(rtc_pkg::A_CTRL, 8'(8'h01 << i));
      end
      host.hostWrite(rtc_pkg::A_CTRL, 8'h00);
      expectReg(rtc_pkg::A_CTRL, 8'h00);
      host.hostWrite(rtc_pkg::A_CAL, 8'h3F);
      expectReg(rtc_pkg::A_CAL, 8'h3F);
      host.hostWrite(rtc_pkg::A_CAL, 8'h1F);
      expectReg(rtc_pkg::A_CAL, 8'h1F);
      host.hostWrite(rtc_pkg::A_CAL, 8'h00);
      endTest("registers");

      host.hostWrite(rtc_pkg::A_TMRVAL, 8'h03);
      cyc(5 * CPM);
      expectReg(rtc_pkg::A_TMRCNT, 8'h03);
      host.hostWrite(rtc_pkg::A_TMRCTL, 8'h04);
      cyc(10 * CPM);
      host.hostWrite(rtc_pkg::A_TMRCTL, 8'h00);
      host.hostRead(rtc_pkg::A_TMRCNT, d);
      check({7'h00, d >= 8'h01 && d <= 8'h03}, 8'h01);
      cyc(3 * CPM);
      expectReg(rtc_pkg::A_FLAGS, 8'h01);
      expectReg(rtc_pkg::A_FLAGS, 8'h00);
      host.hostWrite(rtc_pkg::A_TMRVAL, 8'hC8);
      host.hostWrite(rtc_pkg::A_TMRCTL, 8'h07);
      cyc(10 * CPM);
      host.hostRead(rtc_pkg::A_TMRCNT, d);
      check({7'h00, d >= 8'hC7 && d <= 8'hC8}, 8'h01);
      host.hostWrite(rtc_pkg::A_TMRCTL, 8'h04);
      cyc(10 * CPM);
      host.hostRead(rtc_pkg::A_TMRCNT, d);
      check({7'h00, d >= 8'hBC && d <= 8'hBF}, 8'h01);
      host.hostWrite(rtc_pkg::A_TMRVAL, 8'h10);
      host.hostWrite(rtc_pkg::A_TMRCTL, 8'h05);
      cyc(2600);
      host.hostRead(rtc_pkg::A_TMRCNT, d);
      check({7'h00, d >= 8'h0D && d <= 8'h0E}, 8'h01);
      host.hostWrite(rtc_pkg::A_TMRCTL, 8'h00);
      endTest("timer");

      host.hostWrite(rtc_pkg::A_CTRL, 8'h10);
      oscFail <= 1'b1;
      cyc(3);
      oscFail <= 1'b0;
      cyc(5);
      check({7'h00, ofAlarm}, 8'h01);
      expectReg(rtc_pkg::A_FLAGS, 8'h10);
      host.hostWrite(rtc_pkg::A_FLAGS, 8'h00);
      cyc(2);
      check({7'h00, ofAlarm}, 8'h00);
      expectReg(rtc_pkg::A_FLAGS, 8'h00);
      host.hostWrite(rtc_pkg::A_CTRL, 8'h00);
      endTest("oscillator fail");

      for (int i = 0; i < 2; i++) begin
         host.hostWrite(rtc_pkg::A_WDOG, wdVal[i]);
         cyc(2);
         check({7'h00, wdogOut}, 8'h00);
         cyc(wdLow[i]);
         check({7'h00, wdogOut}, 8'h00);
         cyc(wdHigh[i]);
         check({7'h00, wdogOut}, 8'h01);
         expectReg(rtc_pkg::A_FLAGS, 8'h08);
         expectReg(rtc_pkg::A_FLAGS, 8'h00);
      end
      host.hostWrite(rtc_pkg::A_WDOG, 8'h00);
      cyc(6000);
      check({7'h00, wdogOut}, 8'h00);
      expectReg(rtc_pkg::A_FLAGS, 8'h00);
      endTest("watchdog");

      pwrFail <= 1'b1;
      cyc(4);
      pwrFail <= 1'b0;
      cyc(2);
      expectReg(rtc_pkg::A_CTRL, 8'h01);
      readMs(m1);
      cyc(10 * CPM);
      readMs(m2);
      check(m2[7:0], m1[7:0]);
      check({6'h00, m2[9:8]}, {6'h00, m1[9:8]});
      host.hostWrite(rtc_pkg::A_CTRL, 8'h00);
      readMs(m1);
      cyc(5 * CPM);
      readMs(m2);
      dt = {3'h0, 8'(m2[7:0] - m1[7:0])};
      check({7'h00, dt inside {[11'h004:11'h006]}}, 8'h01);
      readMs(m1);
      ce <= 1'b0;
      cyc(10 * CPM);
      ce <= 1'b1;
      readMs(m2);
      dt = {3'h0, 8'(m2[7:0] - m1[7:0])};
      check({7'h00, dt <= 11'h001}, 8'h01);
      endTest("halt");

      setAlarm(5'h10, 8'h02);
      setAlarm(5'h18, 8'h02);
      host.hostWrite(rtc_pkg::A_CTRL, 8'h80);
      host.hostWrite(rtc_pkg::A_SEC, 8'h01);
      host.hostWrite(rtc_pkg::A_TMRVAL, 8'h05);
      host.hostWrite(rtc_pkg::A_TMRCTL, 8'h06);
      cyc(1050 * CPM);
      expectReg(rtc_pkg::A_FLAGS, 8'h04);
      expectReg(rtc_pkg::A_FLAGS, 8'h00);
      expectReg(rtc_pkg::A_TMRCNT, 8'h04);
      host.hostWrite(rtc_pkg::A_TMRCTL, 8'h00);
      setAlarm(5'h18, 8'h04);
      host.hostWrite(rtc_pkg::A_CTRL, 8'hC0);
      host.hostWrite(rtc_pkg::A_SEC, 8'h03);
      cyc(1050 * CPM);
      expectReg(rtc_pkg::A_FLAGS, 8'h02);
      expectReg(rtc_pkg::A_FLAGS, 8'h00);
      endTest("alarms");
      complete_run();
   end
endmodule
`default_nettype wire
